// [src/serial_adc_regs.vh]
`ifndef SERIAL_ADC_REGS_VH
`define SERIAL_ADC_REGS_VH

// System clock rate in Hz
`define SADC_CLK_HZ 100000000
// Serial bit rates in bit/s
`define SADC_ADDR_RATE_BPS 15000
`define SADC_DATA_RATE_BPS 20000

// Configuration word layout (bit 7 leaves the shifter first)
`define SADC_CFG_WIDTH 8
`define SADC_CFG_START 7
`define SADC_CFG_INPUT_MODE 6
`define SADC_CFG_POLARITY 5
`define SADC_CFG_CHAN_HI 4
`define SADC_CFG_CHAN_LO 3
`define SADC_CFG_UNIPOLAR 2
`define SADC_CFG_MSB_FIRST 1
`define SADC_CFG_PAD 0

// Frame lengths and result field position
`define SADC_ADDR_BITS 8
`define SADC_DATA_BITS 16
`define SADC_RESULT_SHIFT 6
`define SADC_RESULT_WIDTH 10

// Reset levels
`define SADC_SELECT_IDLE 1'b1
`define SADC_SCLK_IDLE 1'b0

`endif

// [src/half_period_divider.v]
`timescale 1ns/1ps
module half_period_divider
#(
  parameter integer HALF_CYCLES = 2500,
  parameter integer CNT_WIDTH = 16
)
(
  input wire ref_clk,
  input wire reset,
  input wire enable,
  output reg tick
);
  reg [CNT_WIDTH-1:0] count_reg;

  // Counter restarts while disabled so the first half period is whole
  always @(posedge ref_clk)
  begin
    if (reset || !enable)
    begin
      count_reg <= {CNT_WIDTH{1'b0}};
      tick <= 1'b0;
    end
    else if (count_reg == HALF_CYCLES[CNT_WIDTH-1:0] - 1'b1)
    begin
      count_reg <= {CNT_WIDTH{1'b0}};
      tick <= 1'b1;
    end
    else
    begin
      count_reg <= count_reg + 1'b1;
      tick <= 1'b0;
    end
  end
endmodule

// [src/serial_adc_sequencer.v]
// Notes on behaviour
// - Word carries start bit and channel selects
// - One bit picks single-ended or differential
// - One bit picks input or pair polarity
// - One bit picks unipolar or bipolar
// - One bit asks for MSB-first result
// - Address and data phases never overlap
// - Result belongs to that converter's previous exchange's address
// - Each result is ten-bit unsigned value
`timescale 1ns/1ps
`include "serial_adc_regs.vh"
module serial_adc_sequencer
#(
  parameter integer ADDR_HALF_CYCLES = `SADC_CLK_HZ / (2 * `SADC_ADDR_RATE_BPS),
  parameter integer DATA_HALF_CYCLES = `SADC_CLK_HZ / (2 * `SADC_DATA_RATE_BPS)
)
(
  input wire ref_clk,
  input wire reset,
  input wire request,
  input wire adcSel,
  input wire single_or_differential_sel,
  input wire inputPolaritySel,
  input wire channel_sel_bit0,
  input wire channel_sel_bit1,
  input wire unipolar_sel,
  input wire msb_first_sel,
  input wire serialDataIn,
  output reg busy,
  output reg resultValid,
  output reg [`SADC_RESULT_WIDTH-1:0] result,
  output reg resultAdc,
  output reg serialClk,
  output reg serialDataOut,
  output reg chipSelect1N,
  output reg chipSelect2N
);
  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_ADDR = 2'd1;
  localparam [1:0] ST_DATA = 2'd2;
  localparam [1:0] ST_GAP = 2'd3;

  reg [1:0] state_reg;
  reg [4:0] bitCnt_reg;
  reg [`SADC_CFG_WIDTH-1:0] shiftOut_reg;
  reg [`SADC_DATA_BITS-1:0] shiftIn_reg;
  reg sdiMeta_reg;
  reg sdiSync_reg;
  reg [`SADC_CFG_WIDTH-1:0] cfgWord;
  wire addrTick;
  wire dataTick;
  wire tick;

  // Serial data pin crosses in from the converter
  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      sdiMeta_reg <= 1'b0;
      sdiSync_reg <= 1'b0;
    end
    else
    begin
      sdiMeta_reg <= serialDataIn;
      sdiSync_reg <= sdiMeta_reg;
    end
  end

  // Separate dividers give each phase its own bit rate
  half_period_divider #(.HALF_CYCLES(ADDR_HALF_CYCLES), .CNT_WIDTH(16)) addrDivider
  (
    .ref_clk(ref_clk),
    .reset(reset),
    .enable(state_reg == ST_ADDR),
    .tick(addrTick)
  );

  half_period_divider #(.HALF_CYCLES(DATA_HALF_CYCLES), .CNT_WIDTH(16)) dataDivider
  (
    .ref_clk(ref_clk),
    .reset(reset),
    .enable((state_reg == ST_DATA) || (state_reg == ST_GAP)),
    .tick(dataTick)
  );

  assign tick = (state_reg == ST_ADDR) ? addrTick : dataTick;

  always @*
  begin
    cfgWord = {`SADC_CFG_WIDTH{1'b0}};
    cfgWord[`SADC_CFG_START] = 1'b1;
    cfgWord[`SADC_CFG_INPUT_MODE] = single_or_differential_sel;
    cfgWord[`SADC_CFG_POLARITY] = inputPolaritySel;
    cfgWord[`SADC_CFG_CHAN_HI] = channel_sel_bit1;
    cfgWord[`SADC_CFG_CHAN_LO] = channel_sel_bit0;
    cfgWord[`SADC_CFG_UNIPOLAR] = unipolar_sel;
    cfgWord[`SADC_CFG_MSB_FIRST] = msb_first_sel;
  end

  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      state_reg <= ST_IDLE;
      bitCnt_reg <= 5'h00;
      shiftOut_reg <= {`SADC_CFG_WIDTH{1'b0}};
      shiftIn_reg <= {`SADC_DATA_BITS{1'b0}};
      busy <= 1'b0;
      resultValid <= 1'b0;
      result <= {`SADC_RESULT_WIDTH{1'b0}};
      resultAdc <= 1'b0;
      serialClk <= `SADC_SCLK_IDLE;
      serialDataOut <= 1'b0;
      chipSelect1N <= `SADC_SELECT_IDLE;
      chipSelect2N <= `SADC_SELECT_IDLE;
    end
    else
    begin
      resultValid <= 1'b0;
      case (state_reg)
        ST_IDLE:
        begin
          if (request)
          begin
            busy <= 1'b1;
            resultAdc <= adcSel;
            // Select owned here, not by the shifter
            chipSelect1N <= adcSel;
            chipSelect2N <= ~adcSel;
            serialDataOut <= cfgWord[`SADC_CFG_WIDTH-1];
            shiftOut_reg <= {cfgWord[`SADC_CFG_WIDTH-2:0], 1'b0};
            bitCnt_reg <= 5'h00;
            state_reg <= ST_ADDR;
          end
        end
        ST_ADDR:
        begin
          if (tick)
          begin
            if (!serialClk)
            begin
              // Data was set up a half period before this rising edge
              serialClk <= 1'b1;
              bitCnt_reg <= bitCnt_reg + 5'h01;
            end
            else
            begin
              serialClk <= 1'b0;
              if (bitCnt_reg == `SADC_ADDR_BITS)
              begin
                // Straight into readback, select still low
                serialDataOut <= 1'b0;
                bitCnt_reg <= 5'h00;
                state_reg <= ST_DATA;
              end
              else
              begin
                serialDataOut <= shiftOut_reg[`SADC_CFG_WIDTH-1];
                shiftOut_reg <= {shiftOut_reg[`SADC_CFG_WIDTH-2:0], 1'b0};
              end
            end
          end
        end
        ST_DATA:
        begin
          if (tick)
          begin
            if (!serialClk)
            begin
              serialClk <= 1'b1;
              shiftIn_reg <= {shiftIn_reg[`SADC_DATA_BITS-2:0], sdiSync_reg};
              bitCnt_reg <= bitCnt_reg + 5'h01;
            end
            else
            begin
              serialClk <= 1'b0;
              if (bitCnt_reg == `SADC_DATA_BITS)
              begin
                chipSelect1N <= `SADC_SELECT_IDLE;
                chipSelect2N <= `SADC_SELECT_IDLE;
                // Value reflects the address of the earlier exchange with the same converter
                result <= shiftIn_reg[`SADC_DATA_BITS-1:`SADC_RESULT_SHIFT];
                resultValid <= 1'b1;
                state_reg <= ST_GAP;
              end
            end
          end
        end
        ST_GAP:
        begin
          // Keep select high one data half period before any new frame
          if (tick)
          begin
            busy <= 1'b0;
            state_reg <= ST_IDLE;
          end
        end
        default:
        begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// [verif/serial_adc_sequencer_monitor.sv]
`timescale 1ns/1ps
module serial_adc_sequencer_monitor
#(
  parameter integer ADDR_HALF_CYCLES = 4,
  parameter integer DATA_HALF_CYCLES = 3
)
(
  input wire ref_clk,
  input wire reset,
  input wire request,
  input wire adcSel,
  input wire busy,
  input wire resultValid,
  input wire serialClk,
  input wire serialDataOut,
  input wire chipSelect1N,
  input wire chipSelect2N
);
  reg [15:0] hw;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  always @(posedge ref_clk)
  begin
    if (reset || !serialClk)
      hw <= 16'h0000;
    else
      hw <= hw + 16'h0001;
  end
  property p_idle; $fell(reset) |-> chipSelect1N && chipSelect2N; endproperty
  a_idle: assert property (p_idle) else $error("select low after reset");
  property p_excl; chipSelect1N || chipSelect2N; endproperty
  a_excl: assert property (p_excl) else $error("both selects low");
  property p_take; request && !busy |=> busy && serialDataOut &&
    ({chipSelect1N, chipSelect2N} == {$past(adcSel), !$past(adcSel)}); endproperty
  a_take: assert property (p_take) else $error("bad frame start");
  property p_frame; serialClk |-> !(chipSelect1N && chipSelect2N); endproperty
  a_frame: assert property (p_frame) else $error("clock outside select");
  property p_end; $rose(chipSelect1N) || $rose(chipSelect2N) |-> resultValid; endproperty
  a_end: assert property (p_end) else $error("select rose early");
  property p_gap; resultValid |=> (chipSelect1N && chipSelect2N) [*2]; endproperty
  a_gap: assert property (p_gap) else $error("no select gap");
  property p_hold; serialClk |-> $stable(serialDataOut); endproperty
  a_hold: assert property (p_hold) else $error("data moved at high clock");
  property p_width; $fell(serialClk) |->
    hw == ADDR_HALF_CYCLES || hw == DATA_HALF_CYCLES; endproperty
  a_width: assert property (p_width) else $error("bad clock width");
endmodule
bind serial_adc_sequencer serial_adc_sequencer_monitor #(.ADDR_HALF_CYCLES(ADDR_HALF_CYCLES),
  .DATA_HALF_CYCLES(DATA_HALF_CYCLES)) u_mon (.ref_clk(ref_clk), .reset(reset),
  .request(request), .adcSel(adcSel), .busy(busy), .resultValid(resultValid),
  .serialClk(serialClk), .serialDataOut(serialDataOut),
  .chipSelect1N(chipSelect1N), .chipSelect2N(chipSelect2N));

// [verif/converter_model.sv]
`timescale 1ns/1ps
module converter_model
#(
  parameter [0:0] ID = 1'b0
)
(
  input wire sclk,
  input wire csN,
  input wire din,
  output reg dout
);
  integer cnt = 0;
  reg [7:0] sh = 8'h00;
  reg [7:0] prevCfg = 8'h00;
  reg [15:0] word = 16'h0000;
  initial dout = 1'b0;
  always @(posedge sclk or posedge csN)
  begin
    if (csN)
      cnt <= 0;
    else
    begin
      cnt <= cnt + 1;
      if (cnt < 8)
        sh <= {sh[6:0], din};
      if (cnt == 7)
      begin
        word <= {ID, prevCfg, 7'h55};
        prevCfg <= {sh[6:0], din};
      end
    end
  end
  // Released line flips so a stale bit never reads as valid
  always @(negedge sclk or posedge csN)
  begin
    if (csN)
      dout <= ~dout;
    else if (cnt >= 8 && cnt < 24)
      dout <= word[23 - cnt];
  end
endmodule

// [verif/serial_adc_sequencer_tb.sv]
`timescale 1ns/1ps
module serial_adc_sequencer_tb;
  reg ref_clk = 1'b0;
  reg reset = 1'b1;
  reg request = 1'b0;
  reg adcSel = 1'b0;
  reg [5:0] cfg = 6'h00;
  reg [31:0] seed = 32'h1718;
  reg [7:0] prevCfg [0:1];
  wire busy, resultValid, resultAdc, serialClk, serialDataOut, cs1N, cs2N, d1, d2;
  wire [9:0] result;
  wire sdi = !cs1N ? d1 : (!cs2N ? d2 : d1);
  integer failures = 0;
  integer nCompared = 0;
  integer i;
  serial_adc_sequencer #(.ADDR_HALF_CYCLES(4), .DATA_HALF_CYCLES(3)) u_serial_adc_sequencer (
    .ref_clk(ref_clk), .reset(reset), .request(request), .adcSel(adcSel),
    .single_or_differential_sel(cfg[5]), .inputPolaritySel(cfg[4]),
    .channel_sel_bit1(cfg[3]), .channel_sel_bit0(cfg[2]), .unipolar_sel(cfg[1]),
    .msb_first_sel(cfg[0]), .serialDataIn(sdi), .busy(busy), .resultValid(resultValid),
    .result(result), .resultAdc(resultAdc), .serialClk(serialClk),
    .serialDataOut(serialDataOut), .chipSelect1N(cs1N), .chipSelect2N(cs2N));
  converter_model #(.ID(1'b0)) u_converter_model (.sclk(serialClk), .csN(cs1N),
    .din(serialDataOut), .dout(d1));
  converter_model #(.ID(1'b1)) u_converter_model_2 (.sclk(serialClk), .csN(cs2N),
    .din(serialDataOut), .dout(d2));
  initial
  begin
    forever #5 ref_clk = ~ref_clk;
  end
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  // Byte the converter latches: start, six options, pad
  function [7:0] sentCfg(input [5:0] c);
    begin
      sentCfg = {1'b1, c, 1'b0};
    end
  endfunction
  // Top result bits: model id, earlier byte, top bit of its fixed tail
  function [9:0] expResult(input a, input [7:0] p);
    begin
      expResult = {a, p, 1'b1};
    end
  endfunction
  task chk(input [47:0] what, input [15:0] seen, input [15:0] exp);
    begin
      nCompared = nCompared + 1;
      if (seen !== exp)
      begin
        failures = failures + 1;
        $display("BAD %0s exp %h seen %h", what, exp, seen);
      end
    end
  endtask
  task xfer(input a, input [5:0] c);
    integer k;
    begin
      k = 0;
      @(posedge ref_clk);
      request <= 1'b1;
      adcSel <= a;
      cfg <= c;
      @(posedge ref_clk);
      request <= 1'b0;
      // Inputs move while busy and must be ignored
      adcSel <= ~a;
      cfg <= ~c;
      while (resultValid !== 1'b1 && k < 400)
      begin
        @(posedge ref_clk);
        k = k + 1;
      end
      chk("result", result, expResult(a, prevCfg[a]));
      chk("adc", resultAdc, a);
      prevCfg[a] = sentCfg(c);
      while (busy !== 1'b0 && k < 400)
      begin
        @(posedge ref_clk);
        k = k + 1;
      end
      if (k >= 400)
        failures = failures + 1;
    end
  endtask
  task print_verdict;
    begin
      $display("compared %0d failures %0d", nCompared, failures);
      if (failures == 0 && nCompared > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial
  begin
    prevCfg[0] = 8'h00;
    prevCfg[1] = 8'h00;
    repeat (20) @(posedge ref_clk);
    chk("sel", {cs1N, cs2N}, 2'b11);
    reset <= 1'b0;
    for (i = 0; i < 14; i = i + 1)
    begin
      seed = xs(seed);
      xfer(i < 4 ? i[0] : seed[8], i < 2 ? 6'h3f : (i < 4 ? 6'h00 : seed[5:0]));
      $display("test %0d done", i);
    end
    // Abort a frame inside the address phase
    request <= 1'b1;
    @(posedge ref_clk);
    request <= 1'b0;
    repeat (12) @(posedge ref_clk);
    reset <= 1'b1;
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    chk("sel", {cs1N, cs2N}, 2'b11);
    xfer(1'b1, 6'h2a);
    $display("test abort done");
    print_verdict;
  end
  initial
  begin
    repeat (6000) @(posedge ref_clk);
    failures = failures + 1;
    print_verdict;
  end
endmodule
